// file: core/nand_host_ctrl.sv
// nand host controller: ahb-lite registers, command/address/read sequencer
// Behaviour
// (RQ1) column twelve bits over two cycles
// (RQ2) page six bits in third cycle
// (RQ3) line six of third cycle: plane bit
// (RQ4) block bits span cycles three to five
// (RQ5) row equals block, plane, page concatenated
// (RQ6) enhanced status read for concurrent results
// (RQ7) device runs two dies concurrently
// (RQ8) identification: command 90h then address
// (RQ9) dummy 00h before status after identification
// (RQ10) identification returns five bytes in order
// (RQ11) identification mode held until next command
// (RQ12) fifth byte bits 1:0 give ecc
// (RQ13) fifth byte bits 3:2 give planes
// (RQ14) fifth byte bits 6:4 give plane size
// (RQ15) parameter read: ECh then address 00h
// (RQ16) parameter mode held until next command
// (RQ17) reset must precede parameter page read
// (RQ18) bytes 0-3 carry ascii signature
// (RQ19) bytes 4-5 revision 02h 00h
// (RQ20) bytes 6-7 features 1Eh 00h
// (RQ21) bytes 8-9 optional commands 3Bh 00h
// (RQ22) command latched by cle at strobe rise
// (RQ23) address latched by ale at strobe rise
// (RQ24) each read strobe fall gives next byte
// (RQ25) address cycle counts nibble-packed byte
// (RQ26) address 00h follows identification command
//
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "nand_host_regs.svh"
module nand_host_ctrl (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output nand_host_pkg::nand_pins_t nand_pins_out,
  input wire logic [7:0] nand_io_in,
  input wire logic nand_rb_in
);

  localparam logic [2:0] STB = 3'(`STROBE_CYC);
  localparam logic [2:0] LAST = 3'(2 * `STROBE_CYC - 1);
  localparam logic [2:0] WB = 3'(`WB_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // one-hot style power of two for 2-bit codes
  function automatic logic [3:0] pow2(input logic [1:0] code);
    pow2 = 4'h1 << code;
  endfunction : pow2

  // read cycles per operation
  function automatic logic [6:0] reads_for(input logic [2:0] op);
    case (op)
      `OP_READ_ID: reads_for = `ID_BYTES;
      `OP_PARAM: reads_for = `PRM_BYTES;
      `OP_READ_PAGE: reads_for = `PAGE_BYTES;
      `OP_RESET: reads_for = 7'h00;
      default: reads_for = 7'h01;
    endcase
  endfunction : reads_for

  // address cycles per operation
  function automatic logic [2:0] addrs_for(input logic [2:0] op);
    case (op)
      `OP_READ_ID, `OP_PARAM: addrs_for = 3'h1;
      `OP_STATUS_ENH: addrs_for = 3'h3;
      `OP_READ_PAGE: addrs_for = 3'h5;
      default: addrs_for = 3'h0;
    endcase
  endfunction : addrs_for

  // first command byte per operation
  function automatic logic [7:0] cmd_for(input logic [2:0] op);
    case (op)
      // (RQ8) identification command
      `OP_READ_ID: cmd_for = `CMD_READ_ID;
      // (RQ15) parameter page command
      `OP_PARAM: cmd_for = `CMD_PARAM;
      `OP_STATUS: cmd_for = `CMD_STATUS;
      // (RQ6) enhanced status command
      `OP_STATUS_ENH: cmd_for = `CMD_STATUS_ENH;
      `OP_READ_PAGE: cmd_for = `CMD_PAGE_READ;
      default: cmd_for = `CMD_RESET;
    endcase
  endfunction : cmd_for

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic dp_valid, dp_write, start_req, done_clr, wp_off, hreadyout, hresp;
  logic next_dp_valid, next_dp_write, next_start_req, next_done_clr, next_wp_off;
  logic [7:0] dp_addr, next_dp_addr;
  logic [2:0] op_sel, next_op_sel;
  logic [11:0] column, next_column;
  logic [18:0] row, next_row;
  logic [31:0] hrdata, next_hrdata, rd_word;

  nand_host_pkg::seq_state_t state, next_state;
  nand_host_pkg::nand_pins_t pins, next_pins;
  nand_host_pkg::addr_bytes_t addr_bytes;
  logic [2:0] tick, next_tick, op, next_op;
  logic [6:0] rep, next_rep;
  logic pre_pending, next_pre_pending, id_mode, next_id_mode, done, next_done;
  logic [7:0] id_byte [5];
  logic [7:0] next_id_byte [5];
  logic [7:0] prm_byte [10];
  logic [7:0] next_prm_byte [10];
  logic [7:0] page_byte [4];
  logic [7:0] next_page_byte [4];
  logic [7:0] prm_cyc, next_prm_cyc, status_byte, next_status_byte;
  logic [7:0] wr_byte, addr_byte;
  logic busy, sig_ok, is_write, is_read;
  logic [3:0] ecc_bits, plane_count;
  logic [12:0] plane_mb;

  assign busy = (state != nand_host_pkg::S_IDLE);
  assign hrdata_out = hrdata;
  assign hreadyout_out = hreadyout;
  assign hresp_out = hresp;
  assign nand_pins_out = pins;

  // address byte builder
  nand_addr_pack u_pack (
    .column_bit_in(column),
    .page_bit_in(row[5:0]),
    .plane_select_bit_in(row[6]),
    .block_bit_in(row[18:7]),
    .addr_out(addr_bytes)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register read view

  // fifth identification byte decode and signature check
  always_comb
  begin
    // (RQ12) ecc bits per 512 bytes
    ecc_bits = pow2(id_byte[4][1:0]);
    // (RQ13) planes per device
    plane_count = pow2(id_byte[4][3:2]);
    // (RQ14) plane size in megabits
    plane_mb = 13'h0040 << id_byte[4][6:4];
    // (RQ18) signature compare
    sig_ok = (prm_byte[0] == `SIG_B0) && (prm_byte[1] == `SIG_B1)
      && (prm_byte[2] == `SIG_B2) && (prm_byte[3] == `SIG_B3);
  end

  // word returned for a read address
  always_comb
  begin
    case (haddr_in[7:0])
      `REG_CTRL: rd_word = {27'h000_0000, wp_off, 1'b0, op_sel};
      `REG_COL: rd_word = {20'h0_0000, column};
      `REG_ROW: rd_word = {13'h0000, row};
      `REG_STATUS: rd_word = {16'h0000, status_byte, 4'h0, id_mode, sig_ok, done, busy};
      `REG_ID0: rd_word = {id_byte[3], id_byte[2], id_byte[1], id_byte[0]};
      `REG_ID1: rd_word = {3'h0, plane_mb, plane_count, ecc_bits, id_byte[4]};
      `REG_PRM0: rd_word = {prm_byte[3], prm_byte[2], prm_byte[1], prm_byte[0]};
      // (RQ19) revision and (RQ20) feature bytes
      `REG_PRM1: rd_word = {prm_byte[7], prm_byte[6], prm_byte[5], prm_byte[4]};
      // (RQ21) optional commands, (RQ25) cycle counts
      `REG_PRM2: rd_word = {8'h00, prm_cyc, prm_byte[9], prm_byte[8]};
      `REG_DATA: rd_word = {page_byte[3], page_byte[2], page_byte[1], page_byte[0]};
      default: rd_word = `RST_WORD;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states

  // address phase capture and register writes
  always_comb
  begin
    next_dp_valid = hsel_in && htrans_in[1] && hready_in && (hsize_in == 3'h2);
    next_dp_write = hwrite_in;
    next_dp_addr = haddr_in[7:0];
    next_op_sel = op_sel;
    next_wp_off = wp_off;
    next_column = column;
    next_row = row;
    next_start_req = 1'b0;
    next_done_clr = 1'b0;
    next_hrdata = hrdata;
    if (next_dp_valid && !hwrite_in)
      next_hrdata = rd_word;
    if (dp_valid && dp_write)
    begin
      case (dp_addr)
        `REG_CTRL:
        begin
          next_op_sel = hwdata_in[`CTRL_OP_MSB:0];
          next_wp_off = hwdata_in[`CTRL_WP_OFF_BIT];
          next_start_req = hwdata_in[`CTRL_START_BIT] && !busy
            && (hwdata_in[`CTRL_OP_MSB:0] <= `OP_READ_PAGE);
        end
        `REG_COL: next_column = hwdata_in[11:0];
        `REG_ROW: next_row = hwdata_in[18:0];
        `REG_STATUS: next_done_clr = hwdata_in[`STATUS_DONE_BIT];
        default: next_done_clr = 1'b0;
      endcase
    end
  end

  // bus-side registers
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= `RST_BYTE;
      op_sel <= `OP_RESET;
      wp_off <= 1'b0;
      column <= 12'h000;
      row <= 19'h0_0000;
      start_req <= 1'b0;
      done_clr <= 1'b0;
      hrdata <= `RST_WORD;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (clk_en_in)
    begin
      dp_valid <= next_dp_valid;
      dp_write <= next_dp_write;
      dp_addr <= next_dp_addr;
      op_sel <= next_op_sel;
      wp_off <= next_wp_off;
      column <= next_column;
      row <= next_row;
      start_req <= next_start_req;
      done_clr <= next_done_clr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flash sequencer

  // byte driven in the current write cycle
  always_comb
  begin
    // (RQ26) zero address after identification
    addr_byte = `ADDR_ZERO;
    if (op == `OP_READ_PAGE)
      addr_byte = addr_bytes[3'(rep)];
    // (RQ7) row bytes pick the die to query
    else if (op == `OP_STATUS_ENH)
      addr_byte = addr_bytes[3'(rep) + 3'h2];
    unique case (state)
      // (RQ17) reset first; (RQ9) dummy after identification
      nand_host_pkg::S_PRE: wr_byte = (op == `OP_PARAM) ? `CMD_RESET : `CMD_DUMMY;
      nand_host_pkg::S_CMD: wr_byte = cmd_for(op);
      nand_host_pkg::S_CMD2: wr_byte = `CMD_PAGE_CONFIRM;
      nand_host_pkg::S_ADDR: wr_byte = addr_byte;
      default: wr_byte = `RST_BYTE;
    endcase
    is_write = (state == nand_host_pkg::S_PRE) || (state == nand_host_pkg::S_CMD)
      || (state == nand_host_pkg::S_CMD2) || (state == nand_host_pkg::S_ADDR);
    is_read = (state == nand_host_pkg::S_READ);
  end

  // next state, pins and captured bytes
  always_comb
  begin
    next_state = state;
    next_pins = pins;
    next_tick = tick;
    next_op = op;
    next_rep = rep;
    next_pre_pending = pre_pending;
    next_id_mode = id_mode;
    next_done = done;
    next_id_byte = id_byte;
    next_prm_byte = prm_byte;
    next_page_byte = page_byte;
    next_prm_cyc = prm_cyc;
    next_status_byte = status_byte;
    next_pins.wp_n = wp_off;
    if (done_clr)
      next_done = 1'b0;
    if (is_write || is_read)
    begin
      next_tick = (tick == LAST) ? 3'h0 : tick + 3'h1;
      if (tick == 3'h0)
      begin
        next_pins.ce_n = 1'b0;
        // (RQ22) cle with command bytes
        next_pins.cle = is_write && (state != nand_host_pkg::S_ADDR);
        // (RQ23) ale with address bytes
        next_pins.ale = (state == nand_host_pkg::S_ADDR);
        next_pins.io_out = wr_byte;
        next_pins.io_oe_n = !is_write;
        next_pins.we_n = !is_write;
        // (RQ24) read strobe fall per byte
        next_pins.re_n = !is_read;
      end
      if (tick == STB)
      begin
        next_pins.we_n = 1'b1;
        next_pins.re_n = 1'b1;
        if (is_read)
        begin
          // (RQ10) id bytes stored in order
          if (op == `OP_READ_ID)
            next_id_byte[3'(rep)] = nand_io_in;
          else if (op == `OP_PARAM && rep < `PRM_KEEP)
            next_prm_byte[4'(rep)] = nand_io_in;
          else if (op == `OP_PARAM && rep == `PRM_CYC_IDX)
            next_prm_cyc = nand_io_in;
          else if (op == `OP_READ_PAGE)
            next_page_byte[2'(rep)] = nand_io_in;
          else
            next_status_byte = nand_io_in;
        end
      end
      if (tick == LAST)
      begin
        next_pins.cle = 1'b0;
        next_pins.ale = 1'b0;
        next_pins.io_oe_n = 1'b1;
      end
    end
    unique case (state)
      nand_host_pkg::S_IDLE:
      begin
        next_tick = 3'h0;
        next_rep = 7'h00;
        if (start_req)
        begin
          next_op = op_sel;
          next_pre_pending = (op_sel == `OP_PARAM);
          if (op_sel == `OP_PARAM)
            next_state = nand_host_pkg::S_PRE;
          // (RQ9) dummy command needed
          else if (id_mode && (op_sel == `OP_STATUS || op_sel == `OP_STATUS_ENH))
            next_state = nand_host_pkg::S_PRE;
          else
            next_state = nand_host_pkg::S_CMD;
        end
      end
      nand_host_pkg::S_PRE:
        if (tick == LAST)
          next_state = pre_pending ? nand_host_pkg::S_WAIT : nand_host_pkg::S_CMD;
      nand_host_pkg::S_CMD:
        if (tick == LAST)
        begin
          next_rep = 7'h00;
          if (addrs_for(op) != 3'h0)
            next_state = nand_host_pkg::S_ADDR;
          else if (op == `OP_RESET)
            next_state = nand_host_pkg::S_WAIT;
          else
            next_state = nand_host_pkg::S_READ;
        end
      nand_host_pkg::S_ADDR:
        if (tick == LAST)
        begin
          next_rep = rep + 7'h01;
          if (rep == 7'(addrs_for(op) - 3'h1))
          begin
            next_rep = 7'h00;
            if (op == `OP_READ_PAGE)
              next_state = nand_host_pkg::S_CMD2;
            else if (op == `OP_PARAM)
              next_state = nand_host_pkg::S_WAIT;
            else
              next_state = nand_host_pkg::S_READ;
          end
        end
      nand_host_pkg::S_CMD2:
        if (tick == LAST)
          next_state = nand_host_pkg::S_WAIT;
      nand_host_pkg::S_WAIT:
      begin
        // settle, then wait for ready
        next_tick = (tick == WB) ? WB : tick + 3'h1;
        if (tick == WB && nand_rb_in)
        begin
          next_tick = 3'h0;
          next_rep = 7'h00;
          next_pre_pending = 1'b0;
          if (pre_pending)
            next_state = nand_host_pkg::S_CMD;
          else if (op == `OP_RESET)
            next_state = nand_host_pkg::S_END;
          else
            next_state = nand_host_pkg::S_READ;
        end
      end
      // (RQ16) reads run on with no new command
      nand_host_pkg::S_READ:
        if (tick == LAST)
        begin
          next_rep = rep + 7'h01;
          if (rep == reads_for(op) - 7'h01)
            next_state = nand_host_pkg::S_END;
        end
      nand_host_pkg::S_END:
      begin
        next_pins.ce_n = 1'b1;
        next_done = 1'b1;
        // (RQ11) identification mode remembered
        next_id_mode = (op == `OP_READ_ID);
        next_state = nand_host_pkg::S_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      state <= nand_host_pkg::S_IDLE;
      pins <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
        wp_n: 1'b0, io_oe_n: 1'b1, io_out: `RST_BYTE};
      tick <= 3'h0;
      op <= `OP_RESET;
      rep <= 7'h00;
      pre_pending <= 1'b0;
      id_mode <= 1'b0;
      done <= 1'b0;
      id_byte <= '{default: `RST_BYTE};
      prm_byte <= '{default: `RST_BYTE};
      page_byte <= '{default: `RST_BYTE};
      prm_cyc <= `RST_BYTE;
      status_byte <= `RST_BYTE;
    end
    else if (clk_en_in)
    begin
      state <= next_state;
      pins <= next_pins;
      tick <= next_tick;
      op <= next_op;
      rep <= next_rep;
      pre_pending <= next_pre_pending;
      id_mode <= next_id_mode;
      done <= next_done;
      id_byte <= next_id_byte;
      prm_byte <= next_prm_byte;
      page_byte <= next_page_byte;
      prm_cyc <= next_prm_cyc;
      status_byte <= next_status_byte;
    end
  end

endmodule : nand_host_ctrl

// file: core/nand_host_regs.svh
// register offsets, fields, command bytes and timing counts of the nand host
`ifndef NAND_HOST_REGS_SVH
`define NAND_HOST_REGS_SVH

// register byte offsets on the ahb-lite slave
`define REG_CTRL 8'h00
`define REG_COL 8'h04
`define REG_ROW 8'h08
`define REG_STATUS 8'h0C
`define REG_ID0 8'h10
`define REG_ID1 8'h14
`define REG_PRM0 8'h18
`define REG_PRM1 8'h1C
`define REG_PRM2 8'h20
`define REG_DATA 8'h24

// ctrl and status field positions
`define CTRL_OP_MSB 2
`define CTRL_START_BIT 3
`define CTRL_WP_OFF_BIT 4
`define STATUS_DONE_BIT 1

// operation codes written to ctrl
`define OP_RESET 3'h0
`define OP_READ_ID 3'h1
`define OP_PARAM 3'h2
`define OP_STATUS 3'h3
`define OP_STATUS_ENH 3'h4
`define OP_READ_PAGE 3'h5

// command bytes sent on the data lines
`define CMD_RESET 8'hFF
`define CMD_READ_ID 8'h90
`define CMD_PARAM 8'hEC
`define CMD_STATUS 8'h70
`define CMD_STATUS_ENH 8'h78
`define CMD_DUMMY 8'h00
`define CMD_PAGE_READ 8'h00
`define CMD_PAGE_CONFIRM 8'h30
`define ADDR_ZERO 8'h00

// parameter page signature bytes
`define SIG_B0 8'h4F
`define SIG_B1 8'h4E
`define SIG_B2 8'h46
`define SIG_B3 8'h49

// transfer lengths
`define ID_BYTES 7'h05
`define PRM_BYTES 7'h66
`define PRM_KEEP 7'h0A
`define PRM_CYC_IDX 7'h65
`define PAGE_BYTES 7'h04

// reset values
`define RST_WORD 32'h0000_0000
`define RST_BYTE 8'h00

// timing: clock period, strobe half width, busy-flag settle
`define CLK_NS 20
`define STROBE_NS 40
`define WB_NS 100
`define STROBE_CYC ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define WB_CYC ((`WB_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// file: core/nand_host_pkg.sv
// types shared by the nand host controller
package nand_host_pkg;

  // strobes and data lines driven toward the flash
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic wp_n;
    logic io_oe_n;
    logic [7:0] io_out;
  } nand_pins_t;

  // five address bytes, index 0 goes out first
  typedef logic [4:0][7:0] addr_bytes_t;

  // sequencer states
  typedef enum logic [2:0] {
    S_IDLE,
    S_PRE,
    S_CMD,
    S_ADDR,
    S_CMD2,
    S_WAIT,
    S_READ,
    S_END
  } seq_state_t;

endpackage : nand_host_pkg

// file: core/nand_addr_pack.sv
// packs column, page, plane and block fields into five address bytes
`timescale 1ns/1ns
module nand_addr_pack (
  input wire logic [11:0] column_bit_in,
  input wire logic [5:0] page_bit_in,
  input wire logic plane_select_bit_in,
  input wire logic [11:0] block_bit_in,
  output nand_host_pkg::addr_bytes_t addr_out
);

  logic [18:0] row;

  // row value: block, then plane, then page
  // (RQ5) row concatenation
  assign row = {block_bit_in, plane_select_bit_in, page_bit_in};

  // byte lanes of the five address cycles
  always_comb
  begin
    // (RQ1) column low byte, masked high nibble
    addr_out[0] = column_bit_in[7:0];
    addr_out[1] = {4'h0, column_bit_in[11:8]};
    // (RQ2) page bits low six
    // (RQ3) plane bit on line six
    addr_out[2] = row[7:0];
    // (RQ4) block bits, upper lines low
    addr_out[3] = row[15:8];
    addr_out[4] = {5'h00, row[18:16]};
  end

endmodule : nand_addr_pack

// file: bench/nand_flash_model.sv
// behavioural flash device answering the host strobes
`timescale 1ns/1ns
module nand_flash_model (
  input wire logic ce_n_in,
  input wire logic cle_in,
  input wire logic ale_in,
  input wire logic we_n_in,
  input wire logic re_n_in,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic rb_out
);
  // maker and device codes are arbitrary; fifth byte: 4 bit ecc, 2 planes, 1 Gb
  // five id bytes, first byte at index 0
  localparam logic [4:0][7:0] IDB = {8'h46, 8'h22, 8'h11, 8'h3C, 8'hA5};
  localparam logic [9:0][7:0] PRM = {8'h00, 8'h3B, 8'h00, 8'h1E, 8'h00, 8'h02, 8'h49,
    8'h46, 8'h4E, 8'h4F};
  int busy_ns = 200;
  int na = 0;
  int idx = 0;
  logic [7:0] cmd = 8'h00;
  logic [7:0] rd_byte = 8'h00;
  logic [4:0][7:0] ab = 40'h00_0000_0000;
  logic rst_seen = 1'b0;
  logic seq_err = 1'b0;
  initial rb_out = 1'b1;
  // busy pulse on ready/busy
  task automatic busy();
    rb_out = 1'b0;
    rb_out <= #(busy_ns) 1'b1;
  endtask : busy
  function automatic logic [7:0] prm(int i);
    if (!rst_seen)
      return 8'h00;
    return (i < 10) ? PRM[i] : ((i == 101) ? 8'h23 : 8'h00);
  endfunction : prm
  always @(posedge we_n_in)
  begin
    if (!ce_n_in && cle_in)
    begin
      if ((io_in == 8'h70 || io_in == 8'h78) && cmd == 8'h90)
        seq_err = 1'b1;
      rst_seen = (io_in == 8'hFF) || (rst_seen && io_in == 8'hEC);
      cmd = io_in;
      na = 0;
      idx = 0;
      if (io_in == 8'hFF || io_in == 8'h30)
        busy();
    end
    else if (!ce_n_in && ale_in)
    begin
      if (cmd == 8'h90 && io_in != 8'h00)
        seq_err = 1'b1;
      ab[na % 5] = io_in;
      na++;
      if (cmd == 8'hEC)
        busy();
    end
  end
  // next byte per read fall, mode held
  always @(negedge re_n_in)
    if (!ce_n_in)
    begin
      case (cmd)
        8'h90: rd_byte = IDB[idx % 5];
        8'hEC: rd_byte = prm(idx);
        8'h70: rd_byte = 8'hE0;
        8'h78: rd_byte = 8'hC1;
        default: rd_byte = ab[0] + idx[7:0];
      endcase
      idx++;
    end
  // released lines show the inverse of the last byte
  assign io_out = (!ce_n_in && !re_n_in) ? rd_byte : ~rd_byte;
endmodule : nand_flash_model

// file: bench/nand_host_ctrl_sva.sv
// assertions on the flash pins of the nand host
`timescale 1ns/1ns
module nand_host_ctrl_sva (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire nand_host_pkg::nand_pins_t nand_pins_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  nand_host_pkg::nand_pins_t p;
  logic [7:0] last_cmd;
  assign p = nand_pins_out;
  ////////////////////////////////////////////////////////////////////////////
  // last command byte seen by the flash
  always_ff @(posedge sys_clk_in)
    if (!reset_n_in)
      last_cmd <= 8'h00;
    else if ($rose(p.we_n) && p.cle)
      last_cmd <= p.io_out;
  ////////////////////////////////////////////////////////////////////////////
  a_latch_excl: assert property (!(p.cle && p.ale))
    else $error("cle and ale high together");
  a_we_width: assert property ($fell(p.we_n) |=> !p.we_n ##1 p.we_n)
    else $error("write strobe width wrong");
  a_we_latch: assert property ($rose(p.we_n) |-> !p.ce_n && !p.io_oe_n && (p.cle || p.ale))
    else $error("write strobe rise without latch");
  a_data_hold: assert property ($fell(p.we_n) |=> $stable(p.io_out)[*2])
    else $error("data moved under write strobe");
  a_re_width: assert property ($fell(p.re_n) |-> p.io_oe_n && !p.ce_n ##1 !p.re_n ##1 p.re_n)
    else $error("read strobe wrong");
  a_no_contention: assert property (!p.re_n |-> p.io_oe_n)
    else $error("host drives during read");
  a_strobe_select: assert property (p.cle || p.ale || !p.re_n |-> !p.ce_n)
    else $error("strobe while deselected");
  a_id_addr_zero: assert property ($rose(p.we_n) && p.ale && last_cmd == 8'h90 |-> p.io_out == 8'h00)
    else $error("id address not zero");
  a_prm_addr_zero: assert property ($rose(p.we_n) && p.ale && last_cmd == 8'hEC |-> p.io_out == 8'h00)
    else $error("parameter address not zero");
  a_dummy_first: assert property ($rose(p.we_n) && p.cle && p.io_out inside {8'h70, 8'h78}
    |-> last_cmd != 8'h90)
    else $error("status right after id");
  a_reset_first: assert property ($rose(p.we_n) && p.cle && p.io_out == 8'hEC |-> last_cmd == 8'hFF)
    else $error("parameter read without reset");
  c_id: cover property ($rose(p.we_n) && p.cle && p.io_out == 8'h90);
  c_prm: cover property ($rose(p.we_n) && p.cle && p.io_out == 8'hEC);
  c_read: cover property ($fell(p.re_n));
endmodule : nand_host_ctrl_sva
bind nand_host_ctrl nand_host_ctrl_sva u_sva (
  .sys_clk_in(sys_clk_in),
  .reset_n_in(reset_n_in),
  .nand_pins_out(nand_pins_out)
);

// file: bench/nand_address_id_param_page_tb.sv
// self-checking bench: host controller with behavioural flash
`timescale 1ns/1ns
`include "nand_host_regs.svh"
module nand_address_id_param_page_tb;
  typedef struct {
    logic [2:0] op;
    logic [7:0] rg;
    logic [31:0] msk;
    logic [31:0] exp;
  } row_t;
  logic sys_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, q;
  logic hready, rb, hresp;
  logic [7:0] flash_out, io_bus;
  nand_host_pkg::nand_pins_t pins;
  int error_cnt = 0;
  int checked = 0;
  row_t rows [11] = '{
    '{`OP_RESET, `REG_STATUS, 32'h0000_0003, 32'h0000_0000},
    '{`OP_READ_ID, `REG_ID0, 32'hFFFF_FFFF, 32'h2211_3CA5},
    '{`OP_READ_ID, `REG_ID1, 32'hFFFF_FFFF, 32'h0400_2446},
    '{`OP_READ_ID, `REG_STATUS, 32'h0000_0008, 32'h0000_0008},
    '{`OP_STATUS, `REG_STATUS, 32'h0000_FF08, 32'h0000_E000},
    '{`OP_PARAM, `REG_PRM0, 32'hFFFF_FFFF, 32'h4946_4E4F},
    '{`OP_PARAM, `REG_PRM1, 32'hFFFF_FFFF, 32'h001E_0002},
    '{`OP_PARAM, `REG_PRM2, 32'hFFFF_FFFF, 32'h0023_003B},
    '{`OP_PARAM, `REG_STATUS, 32'h0000_0004, 32'h0000_0004},
    '{`OP_STATUS_ENH, `REG_STATUS, 32'h0000_FF00, 32'h0000_C100},
    '{`OP_READ_PAGE, `REG_DATA, 32'hFFFF_FFFF, 32'h5F5E_5D5C}
  };
  assign io_bus = !pins.io_oe_n ? pins.io_out : flash_out;
  nand_host_ctrl DUT (
    .sys_clk_in(sys_clk), .reset_n_in(reset_n), .clk_en_in(1'b1), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .nand_pins_out(pins), .nand_io_in(io_bus), .nand_rb_in(rb)
  );
  nand_flash_model m (
    .ce_n_in(pins.ce_n), .cle_in(pins.cle), .ale_in(pins.ale), .we_n_in(pins.we_n),
    .re_n_in(pins.re_n), .io_in(io_bus), .io_out(flash_out), .rb_out(rb)
  );
  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end
  // one ahb-lite single word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : bus
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk
  // start an operation, wait for done, clear it
  task automatic run_op(input logic [2:0] op);
    logic [31:0] s;
    bus(1'b1, `REG_CTRL, {27'h000_0000, 1'b1, 1'b1, op}, s);
    s = 32'h0000_0000;
    while (s[`STATUS_DONE_BIT] !== 1'b1)
      bus(1'b0, `REG_STATUS, 32'h0000_0000, s);
    bus(1'b1, `REG_STATUS, 32'h0000_0002, s);
    @(posedge sys_clk); // clear lands a cycle late
  endtask : run_op
  // counts and verdict
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial
  begin
    #1_000_000;
    error_cnt++;
    $display("MISMATCH %0t watchdog expired", $time);
    wrap_up();
  end
  // main sequence
  initial
  begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    chk({17'h0_0000, pins}, 32'h0000_4D00, "idle pins");
    @(posedge sys_clk);
    for (int a = 0; a <= 'h28; a += 4)
    begin
      bus(1'b0, a[7:0], 32'h0000_0000, q);
      chk(q, (a == 'h14) ? 32'h0040_1100 : 32'h0000_0000, "reset value");
    end
    bus(1'b1, 8'h28, 32'hFFFF_FFFF, q);
    bus(1'b0, 8'h28, 32'h0000_0000, q);
    chk(q, 32'h0000_0000, "unmapped write");
    chk({31'h0000_0000, hresp}, 32'h0000_0000, "bus response");
    $display("test reset done");
    bus(1'b1, `REG_COL, 32'h0000_0A5C, q);
    bus(1'b1, `REG_ROW, 32'h0005_9CEB, q);
    foreach (rows[i])
    begin
      run_op(rows[i].op);
      bus(1'b0, rows[i].rg, 32'h0000_0000, q);
      chk(q & rows[i].msk, rows[i].exp, "table row");
    end
    chk(m.ab[3:0], 32'h9CEB_0A5C, "address bytes");
    chk({24'h00_0000, m.ab[4]}, 32'h0000_0005, "fifth address");
    run_op(`OP_STATUS_ENH);
    chk({8'h00, m.ab[2:0]}, 32'h0005_9CEB, "enhanced row");
    chk({31'h0000_0000, pins.wp_n}, 32'h0000_0001, "write protect off");
    $display("test table done");
    m.busy_ns = 3000;
    bus(1'b1, `REG_COL, 32'h0000_0FFF, q);
    bus(1'b1, `REG_ROW, 32'h0007_FFFF, q);
    run_op(`OP_READ_PAGE);
    bus(1'b0, `REG_DATA, 32'h0000_0000, q);
    chk(q, 32'h0201_00FF, "page data wrap");
    chk(m.ab[3:0], 32'hFFFF_0FFF, "top address");
    chk({24'h00_0000, m.ab[4]}, 32'h0000_0007, "top block");
    chk({31'h0000_0000, m.seq_err}, 32'h0000_0000, "sequence order");
    $display("test boundary done");
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    bus(1'b0, `REG_ID0, 32'h0000_0000, q);
    chk(q, 32'h0000_0000, "id after reset");
    $display("test second reset done");
    wrap_up();
  end
endmodule : nand_address_id_param_page_tb
